// *** hdl/fplc_defs.svh ***
// register offsets, field positions, reset values and constants of the fuse controller
`ifndef FPLC_DEFS_SVH
`define FPLC_DEFS_SVH
`define FPLC_A_PGM_CTRL    16'h3d80
`define FPLC_A_LOAD_CTRL   16'h3d81
`define FPLC_A_PGM_PULSE   16'h3d82
`define FPLC_A_LOAD_PULSE  16'h3d83
`define FPLC_A_MODE_CTRL   16'h3d84
`define FPLC_A_BIST_CFG    16'h3d85
`define FPLC_A_BUF_TEST    16'h3d86
`define FPLC_A_PS2CS       16'h3d87
`define FPLC_A_START_H     16'h3d88
`define FPLC_A_START_L     16'h3d89
`define FPLC_A_END_H       16'h3d8a
`define FPLC_A_END_L       16'h3d8b
`define FPLC_A_FAIL_H      16'h3d8e
`define FPLC_A_FAIL_L      16'h3d8f
`define FPLC_A_BASE_H      16'h3d90
`define FPLC_A_BASE_L      16'h3d91
`define FPLC_A_PGEN_TIME   16'h3d92
`define FPLC_A_GAP_PGM     16'h3d94
`define FPLC_A_GAP_LOAD    16'h3d95
`define FPLC_RST_PGM_PULSE 8'h65
`define FPLC_RST_LOAD_PULSE 8'h06
`define FPLC_RST_MODE      8'h00
`define FPLC_RST_BIST_CFG  8'h1b
`define FPLC_RST_BUF_TEST  8'h0f
`define FPLC_RST_PS2CS     8'h0a
`define FPLC_RST_ADDR      8'h00
`define FPLC_RST_PGEN_TIME 8'he2
`define FPLC_RST_GAP_PGM   8'h12
`define FPLC_RST_GAP_LOAD  8'h06
`define FPLC_B_BUSY        7
`define FPLC_B_BIST_ERR    5
`define FPLC_B_BIST_DONE   4
`define FPLC_B_BIST_CLR    2
`define FPLC_B_AUTOLOAD    1
`define FPLC_B_START       0
`define FPLC_B_PGM_DIS     7
`define FPLC_B_MANUAL      6
`define FPLC_B_BANK        0
`define FPLC_B_DEBUG       7
`define FPLC_B_BIST_CMP    6
`define FPLC_B_BIST_MODE   5
`define FPLC_B_BIST_EN     4
`define FPLC_B_BUF_TM      4
`define FPLC_PGM_UNIT_SH   3
`define FPLC_ONE16         16'h0001
`define FPLC_ZERO16        16'h0000
`define FPLC_AUTO_LAST     16'h007f
`define FPLC_F_PGEN_END    7:4
`define FPLC_F_PGEN_START  3:0
`endif

// *** hdl/fplc_pkg.sv ***
// types shared by the fuse program and load controller
`default_nettype none
package fplc_pkg;
  typedef enum logic [2:0] {
    FPLC_IDLE  = 3'b000,
    FPLC_PWR   = 3'b001,
    FPLC_PGEN  = 3'b010,
    FPLC_STRB  = 3'b011,
    FPLC_GAP   = 3'b100,
    FPLC_CLOSE = 3'b101
  } fplc_state_e;

  typedef struct packed {
    logic        power_select;
    logic        chip_select_n;
    logic        prog_enable_n;
    logic        strobe;
    logic        write_mode;
    logic        bank_switch;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } fplc_mem_s;

  typedef struct packed {
    logic       test_enable;
    logic [2:0] read_margin;
  } fplc_buf_s;
endpackage : fplc_pkg
`default_nettype wire

// *** hdl/fplc_ctrl.sv ***
// fuse memory program, load and self-test controller with its register file
// Summary of operation
// RQ1: program control reads write-busy at bit 7; writing bit 0 starts programming.
// RQ2: load control reads read-busy at bit 7; bit 0 starts load, bit 1 autoload.
// RQ3: load control reads self-test error/done at bits 5/4; bit 2 clears them.
// RQ4: programming strobe width is register value times eight clocks, reset 0x65.
// RQ5: loading strobe width is register value in clocks, reset 0x06.
// RQ6: mode bit 7 set refuses programming.
// RQ7: mode bit 6 picks auto (0) or manual (1) address range.
// RQ8: mode bit 0 is bank/buffer switch; bits 5..1 reserved.
// RQ9: manual start address from high and low bytes, reset zero.
// RQ10: manual end address from high and low bytes, reset zero.
// RQ11: failing self-test address is captured and readable as two bytes.
// RQ12: self-test config bits 4..7: enable, mode, compare value, debug; reset 0x1b.
// RQ13: power select leads chip select by register value clocks, reset 0x0a.
// RQ14: program-enable timing holds end in 7..4 and start in 3..0, reset 0xe2.
// RQ15: programming inserts a configurable gap between strobes, reset 0x12.
// RQ16: loading inserts a configurable gap between strobes, reset 0x06.
// RQ17: buffer test register drives test enable bit 4 and read margin 2..0.
// RQ18: busy sets on command acceptance and clears after the last strobe ends.
// RQ19: software waits for both busy flags clear before new commands or timing changes.
`timescale 1ns/100ps
`include "fplc_defs.svh"
`default_nettype none
module fplc_ctrl
  import fplc_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  output fplc_mem_s        mem_o,
  input  wire logic [7:0]  mem_rdata,
  output fplc_buf_s        buf_o,
  output logic             buf_wr,
  output logic      [15:0] buf_addr,
  output logic      [7:0]  buf_wdata,
  input  wire logic [7:0]  buf_rdata,
  output logic             autoload_r
);

  logic [7:0]  pgm_pulse_r;
  logic [7:0]  load_pulse_r;
  logic [7:0]  mode_r;
  logic [7:0]  bist_cfg_r;
  logic [7:0]  buf_test_r;
  logic [7:0]  ps2cs_r;
  logic [7:0]  start_h_r;
  logic [7:0]  start_l_r;
  logic [7:0]  end_h_r;
  logic [7:0]  end_l_r;
  logic [7:0]  base_h_r;
  logic [7:0]  base_l_r;
  logic [7:0]  pgen_time_r;
  logic [7:0]  gap_pgm_r;
  logic [7:0]  gap_load_r;
  logic        wr_busy_r;
  logic        rd_busy_r;
  logic        bist_err_r;
  logic        bist_done_r;
  logic [15:0] fail_addr_r;
  fplc_state_e state_r;
  logic [15:0] cnt_r;
  logic [15:0] cur_r;
  logic [15:0] last_r;
  logic        is_pgm_r;
  logic        bist_run_r;
  logic        sample_r;

  logic wr_pgm;
  logic wr_load;
  logic start_pgm;
  logic start_load;
  logic idle;
  logic last_addr;
  logic [15:0] strobe_len;
  logic [15:0] gap_len;
  logic [15:0] range_first;
  logic [15:0] range_last;
  logic        bist_bit;
  logic        bist_fail;
  logic [15:0] pgen_lead;
  logic [15:0] pgen_tail;
  logic [15:0] fetch_addr;

  assign idle       = (state_r == FPLC_IDLE);
  assign wr_pgm     = reg_wr && (reg_addr == `FPLC_A_PGM_CTRL);
  assign wr_load    = reg_wr && (reg_addr == `FPLC_A_LOAD_CTRL);
  // programming refused while locked; both refused while another operation runs
  assign start_pgm  = wr_pgm && reg_wdata[`FPLC_B_START] && !mode_r[`FPLC_B_PGM_DIS] && idle; // RQ1 RQ6
  assign start_load = wr_load && reg_wdata[`FPLC_B_START] && idle && !start_pgm; // RQ2
  assign last_addr  = (cur_r == last_r);
  assign strobe_len = is_pgm_r ? {5'h00, pgm_pulse_r, 3'h0} : {8'h00, load_pulse_r}; // RQ4 RQ5
  assign gap_len    = is_pgm_r ? {8'h00, gap_pgm_r} : {8'h00, gap_load_r}; // RQ15 RQ16
  // manual mode uses the programmed range, auto mode addresses 0 through 0x7f
  assign range_first = mode_r[`FPLC_B_MANUAL] ? {start_h_r, start_l_r} : `FPLC_ZERO16; // RQ7 RQ9
  assign range_last  = mode_r[`FPLC_B_MANUAL] ? {end_h_r, end_l_r} : `FPLC_AUTO_LAST; // RQ7 RQ10
  // self-test: bit under test per compare value or mode select inverts per address
  assign bist_bit  = bist_cfg_r[`FPLC_B_BIST_CMP] ^ (bist_cfg_r[`FPLC_B_BIST_MODE] & cur_r[0]); // RQ12
  assign bist_fail = bist_run_r && sample_r && (mem_rdata != {8{bist_bit}});
  // program-enable lead before the first strobe, and a closing time after the last with program enable released
  assign pgen_lead  = {12'h000, pgen_time_r[`FPLC_F_PGEN_START]}; // RQ14
  assign pgen_tail  = {12'h000, pgen_time_r[`FPLC_F_PGEN_END]}; // RQ14
  // programming fetches buffer data one address ahead so it meets the next strobe
  assign fetch_addr = (is_pgm_r && state_r == FPLC_GAP && cnt_r <= `FPLC_ONE16) ?
                      cur_r + `FPLC_ONE16 : cur_r;

  // configuration registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pgm_pulse_r  <= `FPLC_RST_PGM_PULSE; // RQ4
      load_pulse_r <= `FPLC_RST_LOAD_PULSE; // RQ5
      mode_r       <= `FPLC_RST_MODE;
      bist_cfg_r   <= `FPLC_RST_BIST_CFG; // RQ12
      buf_test_r   <= `FPLC_RST_BUF_TEST; // RQ17
      ps2cs_r      <= `FPLC_RST_PS2CS; // RQ13
      start_h_r    <= `FPLC_RST_ADDR; // RQ9
      start_l_r    <= `FPLC_RST_ADDR;
      end_h_r      <= `FPLC_RST_ADDR; // RQ10
      end_l_r      <= `FPLC_RST_ADDR;
      base_h_r     <= `FPLC_RST_ADDR;
      base_l_r     <= `FPLC_RST_ADDR;
      pgen_time_r  <= `FPLC_RST_PGEN_TIME; // RQ14
      gap_pgm_r    <= `FPLC_RST_GAP_PGM; // RQ15
      gap_load_r   <= `FPLC_RST_GAP_LOAD; // RQ16
    end else if (reg_wr) begin
      unique case (reg_addr)
        `FPLC_A_PGM_PULSE:  pgm_pulse_r  <= reg_wdata;
        `FPLC_A_LOAD_PULSE: load_pulse_r <= reg_wdata;
        // reserved mode bits stay zero
        `FPLC_A_MODE_CTRL:  mode_r <= {reg_wdata[`FPLC_B_PGM_DIS], reg_wdata[`FPLC_B_MANUAL], 5'h00,
                                       reg_wdata[`FPLC_B_BANK]}; // RQ6 RQ7 RQ8
        `FPLC_A_BIST_CFG:   bist_cfg_r   <= {reg_wdata[7:4], 4'h0};
        `FPLC_A_BUF_TEST:   buf_test_r   <= {3'h0, reg_wdata[`FPLC_B_BUF_TM], 1'b0, reg_wdata[2:0]};
        `FPLC_A_PS2CS:      ps2cs_r      <= reg_wdata;
        `FPLC_A_START_H:    start_h_r    <= reg_wdata;
        `FPLC_A_START_L:    start_l_r    <= reg_wdata;
        `FPLC_A_END_H:      end_h_r      <= reg_wdata;
        `FPLC_A_END_L:      end_l_r      <= reg_wdata;
        `FPLC_A_BASE_H:     base_h_r     <= reg_wdata;
        `FPLC_A_BASE_L:     base_l_r     <= reg_wdata;
        `FPLC_A_PGEN_TIME:  pgen_time_r  <= reg_wdata;
        `FPLC_A_GAP_PGM:    gap_pgm_r    <= reg_wdata;
        `FPLC_A_GAP_LOAD:   gap_load_r   <= reg_wdata;
        default: ;
      endcase
    end
  end

  // register read mux, one cycle latency
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `FPLC_A_PGM_CTRL:   reg_rdata <= {wr_busy_r, 7'h00}; // RQ1
        `FPLC_A_LOAD_CTRL:  reg_rdata <= {rd_busy_r, 1'b0, bist_err_r, bist_done_r, 4'h0}; // RQ2 RQ3
        `FPLC_A_PGM_PULSE:  reg_rdata <= pgm_pulse_r;
        `FPLC_A_LOAD_PULSE: reg_rdata <= load_pulse_r;
        `FPLC_A_MODE_CTRL:  reg_rdata <= mode_r;
        `FPLC_A_BIST_CFG:   reg_rdata <= bist_cfg_r;
        `FPLC_A_BUF_TEST:   reg_rdata <= buf_test_r;
        `FPLC_A_PS2CS:      reg_rdata <= ps2cs_r;
        `FPLC_A_START_H:    reg_rdata <= start_h_r;
        `FPLC_A_START_L:    reg_rdata <= start_l_r;
        `FPLC_A_END_H:      reg_rdata <= end_h_r;
        `FPLC_A_END_L:      reg_rdata <= end_l_r;
        `FPLC_A_FAIL_H:     reg_rdata <= fail_addr_r[15:8]; // RQ11
        `FPLC_A_FAIL_L:     reg_rdata <= fail_addr_r[7:0];
        `FPLC_A_BASE_H:     reg_rdata <= base_h_r;
        `FPLC_A_BASE_L:     reg_rdata <= base_l_r;
        `FPLC_A_PGEN_TIME:  reg_rdata <= pgen_time_r;
        `FPLC_A_GAP_PGM:    reg_rdata <= gap_pgm_r;
        `FPLC_A_GAP_LOAD:   reg_rdata <= gap_load_r;
        default:            reg_rdata <= 8'h00;
      endcase
    end
  end

  // autoload selector captured with each load command
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      autoload_r <= 1'b0;
    end else if (start_load) begin
      autoload_r <= reg_wdata[`FPLC_B_AUTOLOAD]; // RQ2
    end
  end

  // access sequencer: power, program-enable setup, strobe, gap, close
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_r    <= FPLC_IDLE;
      cnt_r      <= `FPLC_ZERO16;
      cur_r      <= `FPLC_ZERO16;
      last_r     <= `FPLC_ZERO16;
      is_pgm_r   <= 1'b0;
      bist_run_r <= 1'b0;
    end else begin
      unique case (state_r)
        FPLC_IDLE: begin
          if (start_pgm || start_load) begin
            state_r    <= FPLC_PWR;
            cnt_r      <= {8'h00, ps2cs_r}; // RQ13
            cur_r      <= range_first;
            last_r     <= range_last;
            is_pgm_r   <= start_pgm;
            bist_run_r <= start_load && bist_cfg_r[`FPLC_B_BIST_EN]; // RQ12
          end
        end
        FPLC_PWR: begin
          if (cnt_r <= `FPLC_ONE16) begin
            state_r <= is_pgm_r ? FPLC_PGEN : FPLC_STRB;
            cnt_r   <= is_pgm_r ? pgen_lead : strobe_len; // RQ14
          end else begin
            cnt_r <= cnt_r - `FPLC_ONE16; // RQ13
          end
        end
        FPLC_PGEN: begin
          if (cnt_r <= `FPLC_ONE16) begin
            state_r <= FPLC_STRB;
            cnt_r   <= strobe_len;
          end else begin
            cnt_r <= cnt_r - `FPLC_ONE16;
          end
        end
        FPLC_STRB: begin
          if (cnt_r <= `FPLC_ONE16) begin
            state_r <= last_addr ? FPLC_CLOSE : FPLC_GAP;
            cnt_r   <= last_addr ? (is_pgm_r ? pgen_tail : `FPLC_ONE16) : gap_len; // RQ14
          end else begin
            cnt_r <= cnt_r - `FPLC_ONE16; // RQ4 RQ5
          end
        end
        FPLC_GAP: begin
          if (cnt_r <= `FPLC_ONE16) begin
            state_r <= FPLC_STRB;
            cnt_r   <= strobe_len;
            cur_r   <= cur_r + `FPLC_ONE16;
          end else begin
            cnt_r <= cnt_r - `FPLC_ONE16; // RQ15 RQ16
          end
        end
        FPLC_CLOSE: begin
          if (cnt_r <= `FPLC_ONE16) begin
            state_r <= FPLC_IDLE;
          end else begin
            cnt_r <= cnt_r - `FPLC_ONE16;
          end
        end
        default: state_r <= FPLC_IDLE;
      endcase
    end
  end

  // busy flags span command acceptance to end of the last strobe and closing time
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wr_busy_r <= 1'b0;
      rd_busy_r <= 1'b0;
    end else begin
      if (start_pgm) begin
        wr_busy_r <= 1'b1; // RQ18
      end else if (state_r == FPLC_CLOSE && cnt_r <= `FPLC_ONE16) begin
        wr_busy_r <= 1'b0;
      end
      if (start_load) begin
        rd_busy_r <= 1'b1; // RQ18
      end else if (state_r == FPLC_CLOSE && cnt_r <= `FPLC_ONE16) begin
        rd_busy_r <= 1'b0;
      end
    end
  end

  // read data sampled on the last cycle of each load strobe
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sample_r <= 1'b0;
    end else begin
      sample_r <= !is_pgm_r && (state_r == FPLC_STRB) && (cnt_r <= `FPLC_ONE16);
    end
  end

  // self-test result: a failure in the same cycle as a clear wins
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      bist_err_r  <= 1'b0;
      bist_done_r <= 1'b0;
      fail_addr_r <= `FPLC_ZERO16;
    end else begin
      // only the first failing address is kept
      if (bist_fail) begin
        bist_err_r <= 1'b1;
        if (!bist_err_r) begin
          fail_addr_r <= cur_r; // RQ11
        end
      end else if (wr_load && reg_wdata[`FPLC_B_BIST_CLR]) begin
        bist_err_r  <= 1'b0; // RQ3
      end
      if (bist_run_r && state_r == FPLC_CLOSE && cnt_r <= `FPLC_ONE16) begin
        bist_done_r <= 1'b1;
      end else if (wr_load && reg_wdata[`FPLC_B_BIST_CLR]) begin
        bist_done_r <= 1'b0; // RQ3
      end
    end
  end

  // memory pins and buffer path
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      // select and program enable rest inactive through reset
      mem_o     <= '{chip_select_n: 1'b1, prog_enable_n: 1'b1, default: '0};
      buf_o     <= '0;
      buf_wr    <= 1'b0;
      buf_addr  <= `FPLC_ZERO16;
      buf_wdata <= 8'h00;
    end else begin
      mem_o.power_select  <= (state_r != FPLC_IDLE); // RQ13
      mem_o.chip_select_n <= (state_r == FPLC_IDLE) || (state_r == FPLC_PWR);
      mem_o.prog_enable_n <= !(is_pgm_r && (state_r == FPLC_PGEN || state_r == FPLC_STRB ||
                               state_r == FPLC_GAP)); // RQ14
      mem_o.strobe        <= (state_r == FPLC_STRB);
      mem_o.write_mode    <= is_pgm_r;
      mem_o.bank_switch   <= mode_r[`FPLC_B_BANK]; // RQ8
      mem_o.addr          <= cur_r + {base_h_r, base_l_r};
      mem_o.wdata         <= buf_rdata;
      buf_o.test_enable   <= buf_test_r[`FPLC_B_BUF_TM]; // RQ17
      buf_o.read_margin   <= buf_test_r[2:0]; // RQ17
      buf_wr              <= sample_r && !bist_run_r;
      buf_addr            <= fetch_addr;
      buf_wdata           <= mem_rdata;
    end
  end

endmodule // fplc_ctrl
`default_nettype wire

// *** verification/fplc_ctrl_sva.sv ***
// port assertions of the fuse program and load controller
`timescale 1ns/100ps
`include "fplc_defs.svh"
`default_nettype none
module fplc_ctrl_sva
  import fplc_pkg::*;
(
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire fplc_mem_s   mem_o,
  input wire logic [7:0]  mem_rdata,
  input wire fplc_buf_s   buf_o,
  input wire logic        buf_wr,
  input wire logic [15:0] buf_addr,
  input wire logic [7:0]  buf_wdata,
  input wire logic [7:0]  buf_rdata,
  input wire logic        autoload_r
);
  logic [7:0]  lp_r, pp_r, gl_r, ps_r, md_r;
  logic [15:0] hi_r, lo_r, pc_r, lp_w, pp_w, gl_w, ps_w;
  logic        seen_r;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // shadow copies of the pulse, load gap, select delay and mode registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      lp_r <= 8'h06;
      pp_r <= 8'h65;
      gl_r <= 8'h06;
      ps_r <= 8'h0a;
      md_r <= 8'h00;
    end else if (reg_wr) begin
      case (reg_addr)
        `FPLC_A_LOAD_PULSE: lp_r <= reg_wdata;
        `FPLC_A_PGM_PULSE:  pp_r <= reg_wdata;
        `FPLC_A_GAP_LOAD:   gl_r <= reg_wdata;
        `FPLC_A_PS2CS:      ps_r <= reg_wdata;
        `FPLC_A_MODE_CTRL:  md_r <= reg_wdata;
        default: ;
      endcase
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      hi_r   <= 16'h0000;
      lo_r   <= 16'h0000;
      pc_r   <= 16'h0000;
      seen_r <= 1'b0;
    end else begin
      hi_r   <= mem_o.strobe ? hi_r + 16'h0001 : 16'h0000;
      lo_r   <= mem_o.strobe ? 16'h0000 : lo_r + 16'h0001;
      pc_r   <= (mem_o.power_select && mem_o.chip_select_n) ? pc_r + 16'h0001 : 16'h0000;
      seen_r <= mem_o.chip_select_n ? 1'b0 : (seen_r | mem_o.strobe);
    end
  end
  // a zero timing value counts as one cycle
  assign lp_w = (lp_r == 8'h00) ? 16'h0001 : {8'h00, lp_r};
  assign pp_w = (pp_r == 8'h00) ? 16'h0001 : {5'h00, pp_r, 3'h0};
  assign gl_w = (gl_r == 8'h00) ? 16'h0001 : {8'h00, gl_r};
  assign ps_w = (ps_r == 8'h00) ? 16'h0001 : {8'h00, ps_r};
  a_select_lead: assert property ($fell(mem_o.chip_select_n) |-> pc_r == ps_w)
    else $error("chip select delay after power select is wrong");
  a_strobe_selected: assert property (mem_o.strobe |-> mem_o.power_select && !mem_o.chip_select_n)
    else $error("strobe outside an active select");
  a_program_refused: assert property (md_r[7] |-> !$rose(mem_o.write_mode))
    else $error("programming started while disabled");
  a_bank_follows: assert property (mem_o.strobe |-> mem_o.bank_switch == md_r[0])
    else $error("bank switch differs from mode register");
  a_load_width: assert property ($fell(mem_o.strobe) && !mem_o.write_mode |-> hi_r == lp_w)
    else $error("load strobe width wrong");
  a_program_width: assert property ($fell(mem_o.strobe) && mem_o.write_mode |-> hi_r == pp_w)
    else $error("program strobe width wrong");
  a_load_gap: assert property ($rose(mem_o.strobe) && seen_r && !mem_o.write_mode |-> lo_r == gl_w)
    else $error("load strobe gap wrong");
  a_buffer_signals: assert property (reg_wr && reg_addr == `FPLC_A_BUF_TEST |-> ##2
    buf_o == {$past(reg_wdata[4], 2), $past(reg_wdata[2:0], 2)})
    else $error("buffer test signals do not follow register");
  a_enable_strobe: assert property (mem_o.strobe && mem_o.write_mode |-> !mem_o.prog_enable_n)
    else $error("program strobe without program enable");
  c_program: cover property ($fell(mem_o.strobe) && mem_o.write_mode);
  c_buffer_write: cover property (buf_wr);
  c_select: cover property ($fell(mem_o.chip_select_n));
endmodule // fplc_ctrl_sva
bind fplc_ctrl fplc_ctrl_sva u_sva (.mclk(mclk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .mem_o(mem_o), .mem_rdata(mem_rdata),
  .buf_o(buf_o), .buf_wr(buf_wr), .buf_addr(buf_addr), .buf_wdata(buf_wdata), .buf_rdata(buf_rdata),
  .autoload_r(autoload_r));
`default_nettype wire

// *** verification/fplc_fuse_model.sv ***
// behavioural fuse array and data buffer beside the controller
`timescale 1ns/100ps
`default_nettype none
module fplc_fuse_model
  import fplc_pkg::*;
(
  input  wire logic        mclk,
  input  wire fplc_mem_s   mem_o,
  input  wire logic        buf_wr,
  input  wire logic [15:0] buf_addr,
  input  wire logic [7:0]  buf_wdata,
  output logic      [7:0]  mem_rdata,
  output logic      [7:0]  buf_rdata
);
  logic [7:0] fuse [256];
  logic [7:0] bufm [256];
  logic [7:0] last_r;
  logic       hold_r;
  logic       rd_w;
  initial begin
    for (int i = 0; i < 256; i++) begin
      fuse[i] = 8'h00;
      bufm[i] = 8'h3c ^ i[7:0];
    end
    fuse[3] = 8'h5a;
    last_r = 8'h00;
    hold_r = 1'b0;
  end
  assign rd_w = mem_o.strobe && !mem_o.write_mode;
  // fuses only ever blow from 0 to 1
  always @(posedge mclk) begin
    hold_r <= rd_w;
    if (rd_w) last_r <= fuse[mem_o.addr[7:0]];
    if (mem_o.strobe && mem_o.write_mode) fuse[mem_o.addr[7:0]] <= fuse[mem_o.addr[7:0]] | mem_o.wdata;
    if (buf_wr) bufm[buf_addr[7:0]] <= buf_wdata;
  end
  // outside a read and the cycle after it the line shows the inverse of the last byte
  assign mem_rdata = (rd_w || hold_r) ? fuse[mem_o.addr[7:0]] : ~last_r;
  assign buf_rdata = bufm[buf_addr[7:0]];
endmodule // fplc_fuse_model
`default_nettype wire

// *** verification/fplc_ctrl_bench.sv ***
// self-checking bench of the fuse program and load controller
`timescale 1ns/100ps
`default_nettype none
module fplc_ctrl_bench;
  import fplc_pkg::*;
  logic        mclk, sys_rst, reg_wr, reg_rd, buf_wr, autoload_r;
  logic [15:0] reg_addr, buf_addr;
  logic [7:0]  reg_wdata, reg_rdata, mem_rdata, buf_wdata, buf_rdata, nbw;
  fplc_mem_s   mem_o;
  fplc_buf_s   buf_o;
  int          n_errors, tests_run, i;
  logic [7:0]  ra [20] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h87, 8'h88, 8'h89,
                           8'h8a, 8'h8b, 8'h8e, 8'h8f, 8'h90, 8'h91, 8'h92, 8'h93, 8'h94, 8'h95};
  logic [7:0]  rv [20] = '{8'h00, 8'h00, 8'h65, 8'h06, 8'h00, 8'h1b, 8'h0f, 8'h0a, 8'h00, 8'h00,
                           8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'he2, 8'h00, 8'h12, 8'h06};
  fplc_ctrl u_dut (.mclk(mclk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .mem_o(mem_o), .mem_rdata(mem_rdata), .buf_o(buf_o),
    .buf_wr(buf_wr), .buf_addr(buf_addr), .buf_wdata(buf_wdata), .buf_rdata(buf_rdata),
    .autoload_r(autoload_r));
  fplc_fuse_model u_mem (.mclk(mclk), .mem_o(mem_o), .buf_wr(buf_wr), .buf_addr(buf_addr),
    .buf_wdata(buf_wdata), .mem_rdata(mem_rdata), .buf_rdata(buf_rdata));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) if (buf_wr === 1'b1) nbw <= nbw + 8'h01;
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= {8'h3d, a};
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdv(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= {8'h3d, a};
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rdv(a, d);
    chk(d, e);
  endtask
  // software waits for both busy flags before the next command
  task automatic idle;
    logic [7:0] a, b;
    int k;
    for (k = 0; k < 4000; k++) begin
      rdv(8'h80, a);
      rdv(8'h81, b);
      if (a[7] === 1'b0 && b[7] === 1'b0) break;
    end
    if (k == 4000) begin
      n_errors++;
      $display("Error at %0t: busy never cleared", $time);
    end
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #200us;
    n_errors++;
    $display("Error at %0t: watchdog expired", $time);
    complete_run();
  end
  initial begin
    sys_rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    nbw = 8'h00;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    for (i = 0; i < 20; i++) rd(ra[i], rv[i]);
    $display("test reset values done");
    wr(8'h8b, 8'ha5);
    rd(8'h8b, 8'ha5);
    wr(8'h8e, 8'hff);
    rd(8'h8e, 8'h00);
    wr(8'h86, 8'h12);
    repeat (2) @(posedge mclk);
    chk({4'h0, buf_o}, 8'h0a);
    $display("test register access done");
    wr(8'h83, 8'h03);
    wr(8'h95, 8'h02);
    wr(8'h87, 8'h04);
    wr(8'h84, 8'h40);
    wr(8'h8b, 8'h05);
    wr(8'h81, 8'h01);
    rd(8'h81, 8'h80);
    idle();
    rd(8'h81, 8'h30);
    rd(8'h8e, 8'h00);
    rd(8'h8f, 8'h03);
    chk(nbw, 8'h00);
    wr(8'h81, 8'h04);
    rd(8'h81, 8'h00);
    $display("test self-test done");
    wr(8'h85, 8'h0b);
    wr(8'h89, 8'h02);
    wr(8'h84, 8'hc0);
    wr(8'h80, 8'h01);
    rd(8'h80, 8'h00);
    wr(8'h82, 8'h01);
    wr(8'h92, 8'h11);
    wr(8'h94, 8'h02);
    wr(8'h84, 8'h41);
    wr(8'h80, 8'h01);
    rd(8'h80, 8'h80);
    idle();
    rd(8'h80, 8'h00);
    for (i = 2; i < 6; i++) chk(u_mem.fuse[i], ((i == 3) ? 8'h5a : 8'h00) | (8'h3c ^ i[7:0]));
    $display("test programming done");
    for (i = 0; i < 2; i++) begin
      nbw = 8'h00;
      wr(8'h84, (i == 0) ? 8'h40 : 8'h00);
      wr(8'h81, 8'h03);
      rd(8'h81, 8'h80);
      chk({7'h00, autoload_r}, 8'h01);
      idle();
      chk(nbw, (i == 0) ? 8'h04 : 8'h80);
    end
    for (i = 2; i < 6; i++) chk(u_mem.bufm[i], ((i == 3) ? 8'h5a : 8'h00) | (8'h3c ^ i[7:0]));
    $display("test load ranges done");
    complete_run();
  end
endmodule // fplc_ctrl_bench
`default_nettype wire
